// ---- logic/tmt_pkg.sv ----
/*
 * Package for the timer-two control and baud select block.
 * Holds the control register address, field positions, reset value and
 * the baud divide count. Assumes a byte-wide special-function bus.
 */
`default_nettype none

package tmt_pkg;

    // Special-function address of the control register.
    localparam logic [7:0] TMT_CTRL_ADDR = 8'hc8;
    // Value of the control register after reset.
    localparam logic [7:0] TMT_CTRL_RESET = 8'h00;
    // Field positions inside the control register.
    localparam int TMT_BIT_OVF = 7;
    localparam int TMT_BIT_EXF = 6;
    localparam int TMT_BIT_RCLK = 5;
    localparam int TMT_BIT_TX_BAUD_SELECT = 4;
    localparam int TMT_BIT_EXEN = 3;
    localparam int TMT_BIT_RUN = 2;
    localparam int TMT_BIT_CT = 1;
    localparam int TMT_BIT_CPRL = 0;
    // Count value at which the next increment overflows.
    localparam logic [15:0] TMT_COUNT_MAX = 16'hffff;
    // Last baud divider value: one baud tick per sixteen overflows.
    localparam logic [3:0] TMT_BAUD_DIV_LAST = 4'hf;

endpackage

`default_nettype wire

// ---- logic/tmt_timer2.sv ----
/*
 * Timer-two control, sixteen bit counter and serial baud clock select.
 * Assumes all pins and the special-function bus are synchronous to
 * core_clk; the prescaled tick comes from the clock control logic.
 */
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Overflow or event flag requests interrupt service.
// - Receive select picks this or other timer.
// - Transmit select picks this or other timer.
// - Enabled trigger falling edge outside baud mode captures or reloads.
// - Run bit gates all counting.
// - Timer mode counts prescale-selected clock ticks.
// - Counter mode counts count pin falling edges.
// - Control register resets zero, address 0xc8.
// - Every sixteenth roll from all ones in baud mode emits baud pulse.
// - Own baud rate is overflow rate over sixteen; other timer overflow passes undivided.
module tmt_timer2 (
    input wire logic core_clk, // System clock, 100 MHz.
    input wire logic resetn, // Asynchronous reset, active low.
    input wire logic clk_en, // Freezes all state while low.
    input wire logic [7:0] sfr_addr, // Special-function address.
    input wire logic sfr_wr, // Byte write strobe.
    input wire logic [7:0] sfr_wdata, // Byte write data.
    input wire logic sfr_bit_wr, // Single bit write strobe.
    input wire logic [2:0] sfr_bit_sel, // Bit number for bit write.
    input wire logic sfr_bit_val, // Value for bit write.
    output logic [7:0] sfr_rdata, // Read data, zero when not selected.
    input wire logic prescale_select, // Selects system clock or tick.
    input wire logic prescale_tick, // Divided clock tick pulse.
    input wire logic count_input_pin, // External count input.
    input wire logic ext_trigger_pin, // External trigger input.
    input wire logic other_timer_ovf, // Overflow pulse of the other timer.
    input wire logic [15:0] reload_value, // Reload word for this timer.
    output logic [15:0] timer_count, // Running count.
    output logic [15:0] capture_value, // Captured count.
    output logic irq_req, // Interrupt service request.
    output logic rx_baud_tick, // Receive baud clock pulse.
    output logic tx_baud_tick // Transmit baud clock pulse.
);

    // Control register fields.
    logic [7:0] timer_two_control;
    logic [7:0] next_ctrl;
    // Counting state.
    logic [15:0] next_count;
    logic [15:0] next_capture;
    logic [3:0] baud_div;
    logic [3:0] next_baud_div;
    // Previous pin levels for falling edge detection.
    logic cnt_pin_d;
    logic trg_pin_d;
    logic own_baud_tick;
    logic next_own_baud_tick;

    // Derived conditions used by several processes.
    logic baud_mode;
    logic inc_en;
    logic ovf;
    logic trg_evt;

    // Field helper so decoding of bits is done in one place.
    function automatic logic fld(input logic [7:0] r, input int pos);
        return r[pos];
    endfunction

    // Combinational decode of counting and trigger conditions.
    always_comb begin
        baud_mode = fld(timer_two_control, tmt_pkg::TMT_BIT_RCLK) |
                    fld(timer_two_control, tmt_pkg::TMT_BIT_TX_BAUD_SELECT);
        if (!fld(timer_two_control, tmt_pkg::TMT_BIT_RUN)) begin
            inc_en = 1'b0;
        end else if (fld(timer_two_control, tmt_pkg::TMT_BIT_CT)) begin
            inc_en = cnt_pin_d & ~count_input_pin;
        end else begin
            inc_en = prescale_select ? 1'b1 : prescale_tick;
        end
        ovf = inc_en && (timer_count == tmt_pkg::TMT_COUNT_MAX);
        trg_evt = fld(timer_two_control, tmt_pkg::TMT_BIT_EXEN) &&
                  !baud_mode && trg_pin_d && !ext_trigger_pin;
    end

    // Next values of the count, capture, flags and baud divider.
    always_comb begin
        next_ctrl = timer_two_control;
        next_count = timer_count;
        next_capture = capture_value;
        next_baud_div = baud_div;
        next_own_baud_tick = 1'b0;
        if (sfr_wr && sfr_addr == tmt_pkg::TMT_CTRL_ADDR) begin
            next_ctrl = sfr_wdata;
        end else if (sfr_bit_wr && sfr_addr == tmt_pkg::TMT_CTRL_ADDR) begin
            next_ctrl[sfr_bit_sel] = sfr_bit_val;
        end
        if (inc_en) begin
            next_count = timer_count + 16'h0001;
        end
        if (ovf) begin
            if (baud_mode) begin
                next_count = reload_value;
                next_baud_div = baud_div + 4'h1;
                next_own_baud_tick = (baud_div == tmt_pkg::TMT_BAUD_DIV_LAST);
            end else begin
                if (!fld(timer_two_control, tmt_pkg::TMT_BIT_CPRL)) begin
                    next_count = reload_value;
                end
                next_ctrl[tmt_pkg::TMT_BIT_OVF] = 1'b1;
            end
        end
        if (trg_evt) begin
            if (fld(timer_two_control, tmt_pkg::TMT_BIT_CPRL)) begin
                next_capture = timer_count;
            end else begin
                next_count = reload_value;
            end
            next_ctrl[tmt_pkg::TMT_BIT_EXF] = 1'b1;
        end
    end

    // Registers; set wins over a software clear since sets come last.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            timer_two_control <= tmt_pkg::TMT_CTRL_RESET;
            timer_count <= 16'h0000;
            capture_value <= 16'h0000;
            baud_div <= 4'h0;
            own_baud_tick <= 1'b0;
            cnt_pin_d <= 1'b1;
            trg_pin_d <= 1'b1;
        end else if (clk_en) begin
            timer_two_control <= next_ctrl;
            timer_count <= next_count;
            capture_value <= next_capture;
            baud_div <= next_baud_div;
            own_baud_tick <= next_own_baud_tick;
            cnt_pin_d <= count_input_pin;
            trg_pin_d <= ext_trigger_pin;
        end
    end

    // Outputs: read data, interrupt request and selected baud ticks.
    always_comb begin
        sfr_rdata = (sfr_addr == tmt_pkg::TMT_CTRL_ADDR) ?
                    timer_two_control : 8'h00;
        irq_req = fld(timer_two_control, tmt_pkg::TMT_BIT_OVF) |
                  fld(timer_two_control, tmt_pkg::TMT_BIT_EXF);
        rx_baud_tick = fld(timer_two_control, tmt_pkg::TMT_BIT_RCLK) ?
                       own_baud_tick : other_timer_ovf;
        tx_baud_tick = fld(timer_two_control, tmt_pkg::TMT_BIT_TX_BAUD_SELECT) ?
                       own_baud_tick : other_timer_ovf;
    end

    AST_RUN_STOPS: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (!timer_two_control[2] && !trg_evt && !$past(sfr_wr) && clk_en)
            |=> timer_count == $past(timer_count))
        else $error("Count moved while stopped.");
    AST_OVF_FLAG: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (ovf && !baud_mode && clk_en) |=> timer_two_control[7])
        else $error("Overflow flag not set.");
    AST_EXF_FLAG: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (trg_evt && clk_en) |=> timer_two_control[6])
        else $error("Event flag not set.");
    // An ignored falling edge must leave the event flag clear.
    AST_TRG_IGN: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (trg_pin_d && !ext_trigger_pin && clk_en && !sfr_wr && !sfr_bit_wr &&
         !timer_two_control[tmt_pkg::TMT_BIT_EXF] &&
         (!timer_two_control[tmt_pkg::TMT_BIT_EXEN] || baud_mode))
            |=> !timer_two_control[tmt_pkg::TMT_BIT_EXF])
        else $error("Trigger not ignored.");
    // A low clock enable must hold the count and the control register.
    AST_FREEZE: assert property (
        @(posedge core_clk) disable iff (!resetn)
        !clk_en |=> (timer_count == $past(timer_count)) &&
            (timer_two_control == $past(timer_two_control)))
        else $error("State moved while clock enable low.");
    // The own baud tick follows the sixteenth overflow, so the divider wrapped.
    AST_BAUD_TICK: assert property (
        @(posedge core_clk) disable iff (!resetn)
        own_baud_tick |-> baud_div == 4'h0)
        else $error("Baud tick not on the sixteenth overflow.");
    AST_CAPTURE: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (trg_evt && timer_two_control[0] && clk_en)
            |=> capture_value == $past(timer_count))
        else $error("Capture missed.");
    AST_ROLL: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (ovf && !timer_two_control[0] && !trg_evt && clk_en)
            |=> timer_count == $past(reload_value))
        else $error("Reload on overflow missed.");
    AST_RX_SEL: assert property (
        @(posedge core_clk) disable iff (!resetn)
        !timer_two_control[5] |-> rx_baud_tick == other_timer_ovf)
        else $error("Receive clock mis-selected.");
    AST_TX_SEL: assert property (
        @(posedge core_clk) disable iff (!resetn)
        !timer_two_control[4] |-> tx_baud_tick == other_timer_ovf)
        else $error("Transmit clock mis-selected.");
    AST_RESET: assert property (
        @(posedge core_clk) $rose(resetn) |-> timer_two_control == 8'h00)
        else $error("Control not zero after reset.");

endmodule

`default_nettype wire

// ---- test/tmt_far_model.sv ----
/* Far-side model: trigger pin, count pin, other timer and baud consumer.
   Assumes it shares core_clk with the timer block. */
`timescale 1ns/10ps
`default_nettype none
module tmt_far_model (
    input wire logic core_clk, // System clock.
    input wire logic rx_baud_tick, // Receive baud pulse.
    input wire logic tx_baud_tick, // Transmit baud pulse.
    output logic ext_trigger_pin, // Idles high.
    output logic count_input_pin, // Idles high.
    output logic other_timer_ovf // One pulse in every eight cycles.
);
    int rx_n = 0; // Receive baud pulses seen.
    int tx_n = 0; // Transmit baud pulses seen.
    logic [2:0] div = 3'h0; // Divider for the other timer.
    initial begin
        {ext_trigger_pin, count_input_pin} = 2'b11;
    end
    // count each baud pulse; the other timer rolls every 8.
    always @(posedge core_clk) begin
        div <= div + 3'h1;
        other_timer_ovf <= (div == 3'h7);
        rx_n <= rx_n + int'(rx_baud_tick);
        tx_n <= tx_n + int'(tx_baud_tick);
    end
    // one falling edge, low two cycles, so it is never missed.
    task automatic pulse(input bit trig);
        @(posedge core_clk) #1;
        if (trig) ext_trigger_pin = 1'b0;
        else count_input_pin = 1'b0;
        repeat (2) @(posedge core_clk);
        #1 {ext_trigger_pin, count_input_pin} = 2'b11;
        repeat (2) @(posedge core_clk);
        // Return off the edge so the caller never races the count update.
        #1;
    endtask
endmodule
`default_nettype wire

// ---- test/timer2_control_and_baud_select_tb.sv ----
/* Self-checking bench for the timer-two control block.
   Assumes the far-side model drives the pins and counts baud pulses. */
`timescale 1ns/10ps
`default_nettype none
module timer2_control_and_baud_select_tb;
    logic core_clk, resetn, sfr_wr, sfr_bit_wr, sfr_bit_val, irq_req;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic [2:0] sfr_bit_sel;
    logic [15:0] reload_value, timer_count, capture_value, c0;
    logic rx_t, tx_t, trig, cnt, oovf;
    logic clk_en, pre_sel, pre_tick;
    int fail_count = 0;
    int checks_done = 0;
    int r0, t0;
    logic [7:0] cfg [3] = '{8'h34, 8'h24, 8'h14};
    int erx [3] = '{8, 8, 256};
    int etx [3] = '{8, 256, 8};
    tmt_timer2 dut (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
        .sfr_bit_wr(sfr_bit_wr), .sfr_bit_sel(sfr_bit_sel),
        .sfr_bit_val(sfr_bit_val), .sfr_rdata(sfr_rdata),
        .prescale_select(pre_sel), .prescale_tick(pre_tick),
        .count_input_pin(cnt), .ext_trigger_pin(trig),
        .other_timer_ovf(oovf), .reload_value(reload_value),
        .timer_count(timer_count), .capture_value(capture_value),
        .irq_req(irq_req), .rx_baud_tick(rx_t), .tx_baud_tick(tx_t));
    tmt_far_model far (.core_clk(core_clk), .rx_baud_tick(rx_t),
        .tx_baud_tick(tx_t), .ext_trigger_pin(trig),
        .count_input_pin(cnt), .other_timer_ovf(oovf));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Every comparison is counted; a mismatch is reported at once.
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Byte write; the strobe drops a cycle later, address stays on 0xc8.
    task automatic wr(input logic [7:0] d);
        @(posedge core_clk) #1;
        {sfr_wdata, sfr_wr} = {d, 1'b1};
        @(posedge core_clk) #1 sfr_wr = 1'b0;
    endtask
    task automatic bw(input logic [2:0] s, input logic v);
        @(posedge core_clk) #1;
        {sfr_bit_sel, sfr_bit_val, sfr_bit_wr} = {s, v, 1'b1};
        @(posedge core_clk) #1 sfr_bit_wr = 1'b0;
    endtask
    task automatic rd(input string what, input logic [7:0] exp);
        chk(what, {8'h00, exp}, {8'h00, sfr_rdata});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // A hang is cut short well after the expected 7200 cycles.
    initial begin
        #200000;
        fail_count++;
        finish_test();
    end
    initial begin
        {resetn, sfr_wr, sfr_bit_wr, sfr_bit_val} = 4'h0;
        {clk_en, pre_sel, pre_tick} = 3'b110;
        {sfr_wdata, sfr_bit_sel, reload_value} = '0;
        sfr_addr = tmt_pkg::TMT_CTRL_ADDR;
        repeat (16) @(posedge core_clk);
        #1 resetn = 1'b1;
        rd("ctrl reset", tmt_pkg::TMT_CTRL_RESET);
        sfr_addr = 8'h99;
        #1 rd("unmapped", 8'h00);
        sfr_addr = tmt_pkg::TMT_CTRL_ADDR;
        wr(8'hff);
        rd("ctrl all ones", 8'hff);
        wr(8'h00);
        rd("ctrl all zeros", 8'h00);
        $display("register test done");
        wr(8'h04);
        c0 = timer_count;
        cyc(10);
        chk("timer running", c0 + 16'h000a, timer_count);
        wr(8'h00);
        c0 = timer_count;
        cyc(10);
        chk("timer stopped", c0, timer_count);
        wr(8'h06);
        c0 = timer_count;
        repeat (3) far.pulse(1'b0);
        chk("counter edges", c0 + 16'h0003, timer_count);
        wr(8'h04);
        clk_en = 1'b0;
        c0 = timer_count;
        wr(8'h00);
        rd("write frozen", 8'h04);
        cyc(8);
        chk("frozen", c0, timer_count);
        {clk_en, pre_sel} = 2'b10;
        c0 = timer_count;
        cyc(10);
        chk("no prescale tick", c0, timer_count);
        pre_tick = 1'b1;
        cyc(5);
        pre_tick = 1'b0;
        chk("prescale ticks", c0 + 16'h0005, timer_count);
        pre_sel = 1'b1;
        $display("count test done");
        reload_value = 16'hfff0;
        wr(8'h08);
        far.pulse(1'b1);
        chk("trigger reload", 16'hfff0, timer_count);
        rd("event flag", 8'h48);
        chk("event irq", 16'h0001, {15'h0, irq_req});
        wr(8'h0c);
        cyc(20);
        rd("overflow flag", 8'h8c);
        chk("overflow irq", 16'h0001, {15'h0, irq_req});
        bw(3'h7, 1'b0);
        rd("flag cleared", 8'h0c);
        chk("irq cleared", 16'h0000, {15'h0, irq_req});
        wr(8'h00);
        c0 = timer_count;
        far.pulse(1'b1);
        chk("trigger ignored", c0, timer_count);
        rd("no event", 8'h00);
        wr(8'h09);
        far.pulse(1'b1);
        chk("capture", c0, capture_value);
        rd("capture flag", 8'h49);
        $display("trigger test done");
        wr(8'h08);
        far.pulse(1'b1);
        for (int i = 0; i < 3; i++) begin
            wr(cfg[i]);
            cyc(300);
            {r0, t0} = {far.rx_n, far.tx_n};
            cyc(2048);
            chk("rx ticks", 16'(erx[i]), 16'(far.rx_n - r0));
            chk("tx ticks", 16'(etx[i]), 16'(far.tx_n - t0));
        end
        $display("baud test done");
        finish_test();
    end
endmodule
`default_nettype wire
